// ===== logic/shutter_pkg.sv
// Purpose: shared constants and types for the shutter override positioner
// Assumes: 125 MHz core clock, position expressed in 100 ms ticks of travel
// Notes:   register offsets are word indices on the plain register port
package shutter_pkg;

  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned TICK_MS         = 100;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W          = 24;
  localparam int unsigned TRAVEL_MAX_S    = 3000;
  localparam int unsigned TICKS_PER_S     = 1000 / TICK_MS;
  localparam int unsigned POS_W           = 16;
  localparam int unsigned TRAVEL_W        = 12;
  localparam int unsigned SCENES          = 8;
  localparam int unsigned SCENE_W         = 3;

  localparam logic [3:0]  REG_CFG         = 4'h0;
  localparam logic [3:0]  REG_TRAVEL      = 4'h1;
  localparam logic [3:0]  REG_CMD         = 4'h2;
  localparam logic [3:0]  REG_STATUS      = 4'h3;
  localparam logic [3:0]  REG_POS         = 4'h4;
  localparam logic [3:0]  REG_SAVED       = 4'h5;

  localparam int unsigned CFG_FB_EN       = 0;
  localparam int unsigned CFG_FORCE_EN    = 1;
  localparam int unsigned CFG_BLOCK_EN    = 2;
  localparam int unsigned CFG_ALARM_EN    = 3;
  localparam int unsigned CFG_SCENE_EN    = 4;
  localparam int unsigned CFG_REL_LSB     = 5;
  localparam int unsigned CFG_REL_W       = 3;

  localparam logic [11:0] TRAVEL_RESET    = 12'h0_0B4;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

  typedef enum logic [2:0]
  {
    REL_UP, REL_DOWN, REL_NONE, REL_PREV, REL_LAST
  } release_t;

  typedef enum logic [3:0]
  {
    CMD_NONE, CMD_UP, CMD_DOWN, CMD_STOP, CMD_POS, CMD_SCENE_RUN, CMD_SCENE_STORE,
    CMD_FORCE_UP, CMD_FORCE_DOWN, CMD_FORCE_OFF, CMD_BLOCK_ON, CMD_BLOCK_OFF,
    CMD_ALARM_ON, CMD_ALARM_OFF
  } cmd_op_t;

  typedef struct packed
  {
    logic          valid;
    cmd_op_t       op;
    logic [2:0]    scene;
    logic [15:0]   pos;
  } cmd_t;

  typedef struct packed
  {
    logic          up;
    logic          down;
  } drive_t;

endpackage

// ===== logic/shutter_override_positioner.sv
// Purpose: position estimate, override arbitration, release policy and scenes for one shutter
// Assumes: telegrams decoded outside; 3-stage bus-power input; nonvolatile forced state outside
// Notes:   position counts 100 ms ticks from 0 (fully open) to travel*10 (fully closed)
module shutter_override_positioner
  import shutter_pkg::*;
(
  input  wire logic                i_core_clk,
  input  wire logic                i_rst,
  input  wire logic [3:0]          i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [31:0]         o_rdata,
  input  wire cmd_t                i_cmd,
  input  wire logic                i_bus_power,
  input  wire logic                i_nv_force_active,
  input  wire logic                i_nv_force_down,
  output logic                     o_nv_force_active,
  output logic                     o_nv_force_down,
  output drive_t                   o_drive,
  output logic                     o_supply_on,
  output logic                     o_fb_pulse,
  output logic                     o_fb_down
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0]          cfg;
  logic [TRAVEL_W-1:0] travel_s;
  logic                fb_en;
  logic                force_en;
  logic                block_en;
  logic                alarm_en;
  logic                scene_en;
  release_t            rel_mode;
  logic [POS_W-1:0]    full_pos;

  assign fb_en    = cfg[CFG_FB_EN];
  assign force_en = cfg[CFG_FORCE_EN];
  assign block_en = cfg[CFG_BLOCK_EN];
  assign alarm_en = cfg[CFG_ALARM_EN];
  assign scene_en = cfg[CFG_SCENE_EN];
  assign rel_mode = release_t'(cfg[CFG_REL_LSB +: CFG_REL_W]);
  // one stroke figure serves both directions; positions are tick fractions of it
  assign full_pos = POS_W'(travel_s * TICKS_PER_S);

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cfg      <= 8'h00;
      travel_s <= TRAVEL_RESET;
    end
    else if (i_wr && i_addr == REG_CFG)
    begin
      cfg <= i_wdata[7:0];
    end
    else if (i_wr && i_addr == REG_TRAVEL)
    begin
      // out-of-range values clamp to the top of the span
      if (i_wdata > TRAVEL_MAX_S)
      begin
        travel_s <= TRAVEL_W'(TRAVEL_MAX_S);
      end
      else
      begin
        travel_s <= i_wdata[TRAVEL_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bus power synchroniser
  // ----------------------------------------------------------------
  logic [2:0] pwr_sync;
  logic       pwr_ok;
  logic       pwr_ok_d;

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pwr_sync <= 3'h0;
      pwr_ok   <= 1'b0;
      pwr_ok_d <= 1'b0;
    end
    else
    begin
      pwr_sync <= {pwr_sync[1:0], i_bus_power};
      if (pwr_sync[2] == pwr_sync[1])
      begin
        pwr_ok <= pwr_sync[1];
      end
      pwr_ok_d <= pwr_ok;
    end
  end

  // ----------------------------------------------------------------
  // tick time base
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else if (tick_cnt == TICK_W'(TICK_CYCLES - 1))
    begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // command qualification and override flags
  // ----------------------------------------------------------------
  logic             force_on;
  logic             force_dn;
  logic             block_on;
  logic             alarm_on;
  logic             any_ovr;
  logic             cmd_ok;
  logic             is_normal;
  logic             normal_ok;
  logic             target_set;
  logic [POS_W-1:0] target;
  logic [POS_W-1:0] pos;
  logic [POS_W-1:0] saved_pos;
  logic             pend_valid;
  cmd_t             pend_cmd;
  logic [POS_W-1:0] scene_mem [SCENES];

  assign any_ovr   = force_on | block_on | alarm_on;
  assign cmd_ok    = i_cmd.valid && pwr_ok;
  assign is_normal = i_cmd.op inside {CMD_UP, CMD_DOWN, CMD_STOP, CMD_POS}
                     || (scene_en && i_cmd.op inside {CMD_SCENE_RUN, CMD_SCENE_STORE});
  assign normal_ok = cmd_ok && is_normal && !any_ovr;

  // forced flag: set from nonvolatile copy on power return, else from bus
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      force_on <= 1'b0;
      force_dn <= 1'b0;
    end
    else if (pwr_ok && !pwr_ok_d)
    begin
      force_on <= force_en && i_nv_force_active;
      force_dn <= i_nv_force_down;
    end
    else if (cmd_ok && force_en)
    begin
      unique case (i_cmd.op)
        CMD_FORCE_UP:
        begin
          force_on <= 1'b1;
          force_dn <= 1'b0;
        end
        CMD_FORCE_DOWN:
        begin
          force_on <= 1'b1;
          force_dn <= 1'b1;
        end
        CMD_FORCE_OFF: force_on <= 1'b0;
        default: ;
      endcase
    end
  end

  // block and alarm are discarded entirely while forced is engaged
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      block_on <= 1'b0;
      alarm_on <= 1'b0;
    end
    else if (cmd_ok && !force_on)
    begin
      if (block_en && i_cmd.op == CMD_BLOCK_ON) block_on <= 1'b1;
      if (block_en && i_cmd.op == CMD_BLOCK_OFF) block_on <= 1'b0;
      if (alarm_en && !block_on && i_cmd.op == CMD_ALARM_ON) alarm_on <= 1'b1;
      if (alarm_en && i_cmd.op == CMD_ALARM_OFF) alarm_on <= 1'b0;
    end
  end

  // follow-last memory of commands that arrive while overridden
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pend_valid <= 1'b0;
      pend_cmd   <= '0;
    end
    else if (!any_ovr)
    begin
      pend_valid <= 1'b0;
    end
    else if (cmd_ok && is_normal && i_cmd.op != CMD_SCENE_STORE)
    begin
      pend_valid <= 1'b1;
      pend_cmd   <= i_cmd;
    end
  end

  // position at engagement, captured when a bus command engages the first override
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      saved_pos <= '0;
    end
    else if (!any_ovr && cmd_ok && (
             (force_en && i_cmd.op inside {CMD_FORCE_UP, CMD_FORCE_DOWN})
             || (block_en && i_cmd.op == CMD_BLOCK_ON)
             || (alarm_en && i_cmd.op == CMD_ALARM_ON)))
    begin
      saved_pos <= pos;
    end
  end

  // scene slots hold a position each
  always_ff @(posedge i_core_clk)
  begin
    if (normal_ok && i_cmd.op == CMD_SCENE_STORE)
    begin
      scene_mem[i_cmd.scene] <= pos;
    end
  end

  // ----------------------------------------------------------------
  // target selection
  // ----------------------------------------------------------------
  logic any_ovr_d;
  logic ovr_release;

  assign ovr_release = any_ovr_d && !any_ovr;

  function automatic logic [POS_W-1:0] cmd_target(input cmd_t c,
                                                  input logic [POS_W-1:0] cur,
                                                  input logic [POS_W-1:0] full,
                                                  input logic [POS_W-1:0] scn);
    logic [POS_W-1:0] t;
    t = cur;
    unique case (c.op)
      CMD_UP:        t = '0;
      CMD_DOWN:      t = full;
      CMD_POS:       t = (c.pos > full) ? full : c.pos;
      CMD_SCENE_RUN: t = (scn > full) ? full : scn;
      default:       t = cur;
    endcase
    return t;
  endfunction

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      any_ovr_d  <= 1'b0;
      target     <= '0;
      target_set <= 1'b0;
    end
    else
    begin
      any_ovr_d  <= any_ovr;
      target_set <= 1'b1;
      if (!target_set || !pwr_ok)
      begin
        target <= pos;
      end
      else if (force_on)
      begin
        target <= force_dn ? full_pos : '0;
      end
      else if (block_on || alarm_on)
      begin
        // block and alarm alike park the load where it stands when the first override engages
        target <= !any_ovr_d ? pos : target;
      end
      else if (ovr_release)
      begin
        unique case (rel_mode)
          REL_UP:   target <= '0;
          REL_DOWN: target <= full_pos;
          REL_PREV: target <= saved_pos;
          REL_LAST: target <= pend_valid
                              ? cmd_target(pend_cmd, pos, full_pos, scene_mem[pend_cmd.scene])
                              : saved_pos;
          default:  target <= pos;
        endcase
      end
      // storing a scene must not stop a run in progress
      else if (normal_ok && i_cmd.op != CMD_SCENE_STORE)
      begin
        target <= cmd_target(i_cmd, pos, full_pos, scene_mem[i_cmd.scene]);
      end
    end
  end

  // ----------------------------------------------------------------
  // motor drive and position estimate
  // ----------------------------------------------------------------
  logic run_up;
  logic run_dn;
  logic was_up;
  logic was_dn;

  assign run_up = pwr_ok && target_set && (target < pos);
  assign run_dn = pwr_ok && target_set && (target > pos);

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pos <= '0;
    end
    else if (pos > full_pos)
    begin
      pos <= full_pos;
    end
    else if (tick && run_dn && pos != full_pos)
    begin
      pos <= pos + 1'b1;
    end
    else if (tick && run_up && pos != '0)
    begin
      pos <= pos - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_drive     <= '0;
      o_supply_on <= 1'b0;
      was_up      <= 1'b0;
      was_dn      <= 1'b0;
      o_fb_pulse  <= 1'b0;
      o_fb_down   <= 1'b0;
    end
    else
    begin
      o_supply_on  <= pwr_ok;
      o_drive.up   <= run_up && !run_dn;
      o_drive.down <= run_dn && !run_up;
      was_up       <= run_up;
      was_dn       <= run_dn;
      o_fb_pulse   <= fb_en && ((run_up && !was_up) || (run_dn && !was_dn));
      if (run_up || run_dn)
      begin
        o_fb_down <= run_dn;
      end
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile copy and register reads
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_nv_force_active <= 1'b0;
      o_nv_force_down   <= 1'b0;
    end
    else
    begin
      o_nv_force_active <= force_on;
      o_nv_force_down   <= force_dn;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= ZERO_WORD;
    end
    else if (i_rd)
    begin
      unique case (i_addr)
        REG_CFG:    o_rdata <= {24'h00_0000, cfg};
        REG_TRAVEL: o_rdata <= {20'h0_0000, travel_s};
        REG_STATUS: o_rdata <= {26'h000_0000, pwr_ok, run_dn, run_up,
                                alarm_on, block_on, force_on};
        REG_POS:    o_rdata <= {target, pos};
        REG_SAVED:  o_rdata <= {15'h0000, pend_valid, saved_pos};
        default:    o_rdata <= ZERO_WORD;
      endcase
    end
    else
    begin
      o_rdata <= ZERO_WORD;
    end
  end

endmodule

// ===== bench/shutter_monitor.sv
// Purpose: port-level checks for the shutter override positioner
// Assumes: one clock, async active-high reset
// Notes:   the position counter does not move in a short run
module shutter_monitor
  import shutter_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_addr,
  input  wire logic        i_rd,
  input  wire logic [31:0] o_rdata,
  input  wire logic        i_bus_power,
  input  wire logic        o_nv_force_active,
  input  wire logic        o_nv_force_down,
  input  wire drive_t      o_drive,
  input  wire logic        o_supply_on,
  input  wire logic        o_fb_pulse,
  input  wire logic        o_fb_down
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // ----------------------------------------
  // forced state held long enough to settle
  // ----------------------------------------
  sequence forced_dn_s;
    (o_nv_force_active && o_nv_force_down) [*4];
  endsequence
  sequence forced_up_s;
    (o_nv_force_active && !o_nv_force_down) [*4];
  endsequence

  AST_DRIVE_EXCL: assert property (!(o_drive.up && o_drive.down))
    else $error("both relay drives on");
  AST_FORCED_DN: assert property (forced_dn_s |-> !o_drive.up)
    else $error("forced down but driving up");
  AST_FORCED_UP: assert property (forced_up_s |-> !o_drive.down)
    else $error("forced up but driving down");
  AST_SUPPLY_ON: assert property (i_bus_power [*7] |-> o_supply_on)
    else $error("supply off with bus power present");
  AST_SUPPLY_OFF: assert property (!i_bus_power [*7] |-> !o_supply_on)
    else $error("supply on without bus power");
  AST_DRIVE_OFF: assert property (!o_supply_on [*2] |-> o_drive == 2'b00)
    else $error("motor driven without supply");
  AST_FB_ONE: assert property (o_fb_pulse |=> !o_fb_pulse)
    else $error("feedback pulse longer than one cycle");
  AST_FB_DIR: assert property (o_fb_pulse |-> (o_drive.up ^ o_drive.down)
    && o_fb_down == o_drive.down)
    else $error("feedback direction disagrees with drive");
  // power loss must not wipe the stored forced copy
  AST_NV_KEEP: assert property ($fell(o_supply_on) |=>
    ($stable(o_nv_force_active) && $stable(o_nv_force_down)) [*3])
    else $error("forced copy changed on power loss");
  AST_TRAVEL_MAX: assert property (i_rd && i_addr == REG_TRAVEL |=>
    o_rdata <= 32'h0000_0BB8)
    else $error("travel time above limit");
endmodule

// ===== bench/telegram_source.sv
// Purpose: group telegram source and bus power for the positioner
// Assumes: telegrams arrive already decoded, one cycle each
// Notes:   idle telegram fields are scrambled, never left stale
module telegram_source
  import shutter_pkg::*;
(
  input  wire logic i_core_clk,
  output cmd_t      o_cmd,
  output logic      o_bus_power
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_cmd = '0;
    o_bus_power = 1'b0;
  end
  task automatic send(input cmd_op_t op, input logic [2:0] scn, input logic [15:0] pos);
    @(posedge i_core_clk);
    o_cmd <= '{valid: 1'b1, op: op, scene: scn, pos: pos};
    @(posedge i_core_clk);
    o_cmd <= '{valid: 1'b0, op: cmd_op_t'(~op), scene: ~scn, pos: ~pos};
    repeat (4) @(posedge i_core_clk);
  endtask
  task automatic power(input logic on);
    @(posedge i_core_clk);
    o_bus_power <= on;
    repeat (16) @(posedge i_core_clk);
  endtask
endmodule

// ===== bench/shutter_override_positioner_test.sv
// Purpose: self-checking bench for the shutter override positioner
// Assumes: 125 MHz clock, short stroke so targets are easy to compute
// Notes:   position stays at 0 within the run; targets are compared
module shutter_override_positioner_test
  import shutter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_core_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic        i_wr = 1'b0, i_rd = 1'b0, i_nv_force_active = 1'b0, i_nv_force_down = 1'b0;
  logic [31:0] o_rdata, rd, seed = 32'h0000_9A4C;
  logic        i_bus_power, o_nv_force_active, o_nv_force_down, o_supply_on, o_fb_pulse, o_fb_down;
  cmd_t        i_cmd;
  drive_t      o_drive;
  int          n_errors = 0, n_tests = 0, tg = 0, last = -1, full, s, scn [8];
  int          n_fb = 0;
  bit          f, fd, b, a;
  logic [4:0]  en;
  release_t    rel;
  release_t    rels [6] = '{REL_UP, REL_DOWN, REL_NONE, REL_PREV, REL_LAST, REL_LAST};
  cmd_op_t     offs [4] = '{CMD_FORCE_DOWN, CMD_BLOCK_ON, CMD_ALARM_ON, CMD_SCENE_RUN};

  initial forever #4 i_core_clk = ~i_core_clk;

  // run-start pulses, counted mid-cycle where the registered output is settled
  always @(negedge i_core_clk)
    if (o_fb_pulse === 1'b1)
      n_fb++;

  telegram_source bus (.i_core_clk, .o_cmd(i_cmd), .o_bus_power(i_bus_power));
  shutter_override_positioner DUT (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_cmd, .i_bus_power, .i_nv_force_active, .i_nv_force_down, .o_nv_force_active,
    .o_nv_force_down, .o_drive, .o_supply_on, .o_fb_pulse, .o_fb_down);

  // ----------------------------------------
  // bus cycles and comparison
  // ----------------------------------------
  function automatic int rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return 1 + int'(seed % full);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= ad;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdx(input logic [3:0] ad, output logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic cfg(input logic [4:0] e, input release_t r);
    en = e;
    rel = r;
    wr(REG_CFG, {24'h00_0000, r, e});
  endtask
  task automatic state();
    rdx(REG_STATUS, rd);
    chk(32'(rd[2:0]), 32'({a, b, f}));
    rdx(REG_POS, rd);
    chk(32'(rd[31:16]), 32'(tg));
    chk(32'(o_drive), 32'(tg > 0));
    if (tg > 0)
      chk(32'(o_fb_down), 32'h0000_0001);
  endtask

  // ----------------------------------------
  // reference model of the override arbiter
  // ----------------------------------------
  task automatic cmd(input cmd_op_t op, input int sc, input int p);
    bit any;
    int t;
    int t0;
    int fb0;
    any = f | b | a;
    t = -1;
    t0 = tg;
    fb0 = n_fb;
    bus.send(op, sc[2:0], p[15:0]);
    case (op)
      CMD_FORCE_UP, CMD_FORCE_DOWN: if (en[1]) {f, fd} = {1'b1, op == CMD_FORCE_DOWN};
      CMD_FORCE_OFF: f &= !en[1];
      CMD_BLOCK_ON: b |= en[2] & !f;
      CMD_BLOCK_OFF: b &= !(en[2] & !f);
      CMD_ALARM_ON: a |= en[3] & !f & !b;
      CMD_ALARM_OFF: a &= !(en[3] & !f);
      CMD_SCENE_STORE: if (en[4] && !any) scn[sc] = 0;
      CMD_UP: t = 0;
      CMD_DOWN: t = full;
      CMD_POS: t = p;
      CMD_SCENE_RUN: if (en[4]) t = scn[sc];
      default: ;
    endcase
    if (t >= 0 && any)
      last = t;
    else if (t >= 0)
      tg = t;
    if (!any && (f | b | a))
      last = -1;
    // block or alarm park where the load stands, which is still the open end
    if (f)
      tg = fd ? full : 0;
    else if (b | a)
      tg = 0;
    else if (any)
      tg = rel == REL_DOWN ? full : (rel == REL_LAST && last >= 0) ? last : 0;
    state();
    // a run starts only when a stopped load gets a target away from the open end
    chk(32'(n_fb - fb0), 32'(en[0] && t0 == 0 && tg > 0));
  endtask

  task automatic final_report();
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    n_errors++;
    final_report();
  end

  initial
  begin
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    bus.power(1'b1);
    rdx(REG_TRAVEL, rd);
    chk(rd, 32'h0000_00B4);
    rdx(4'hF, rd);
    chk(rd, 32'h0000_0000);
    wr(REG_TRAVEL, 32'h0000_0FA0);
    rdx(REG_TRAVEL, rd);
    chk(rd, 32'h0000_0BB8);
    wr(REG_TRAVEL, 32'h0000_0002);
    full = 2 * TICKS_PER_S;
    foreach (rels[i])
    begin
      cfg(5'h1F, rels[i]);
      cmd(CMD_POS, 0, rnd());
      cmd(CMD_FORCE_DOWN, 0, 0);
      cmd(CMD_BLOCK_ON, 0, 0);
      cmd(CMD_FORCE_OFF, 0, 0);
      cmd(CMD_BLOCK_ON, 0, 0);
      cmd(CMD_ALARM_ON, 0, 0);
      if (i == 4)
        cmd(CMD_POS, 0, rnd());
      cmd(CMD_FORCE_UP, 0, 0);
      cmd(CMD_FORCE_OFF, 0, 0);
      cmd(CMD_BLOCK_OFF, 0, 0);
      cmd(CMD_ALARM_ON, 0, 0);
      cmd(CMD_DOWN, 0, 0);
      cmd(CMD_ALARM_OFF, 0, 0);
    end
    cfg(5'h1F, REL_NONE);
    s = rnd() % SCENES;
    cmd(CMD_SCENE_STORE, s, 0);
    cmd(CMD_POS, 0, rnd());
    cmd(CMD_SCENE_RUN, s, 0);
    cfg(5'h00, REL_DOWN);
    cmd(CMD_POS, 0, rnd());
    foreach (offs[k])
      cmd(offs[k], 0, 0);
    cfg(5'h1F, REL_NONE);
    cmd(CMD_FORCE_DOWN, 0, 0);
    // the outside store keeps what the block hands it
    @(posedge i_core_clk);
    i_nv_force_active <= o_nv_force_active;
    i_nv_force_down <= o_nv_force_down;
    bus.power(1'b0);
    chk(32'({o_supply_on, o_drive}), 32'h0000_0000);
    // a reset while the bus is down leaves only the outside copy of the forced state
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    chk(32'({o_nv_force_active, o_nv_force_down}), 32'h0000_0000);
    i_rst <= 1'b0;
    cfg(5'h1F, REL_NONE);
    wr(REG_TRAVEL, 32'h0000_0002);
    bus.power(1'b1);
    state();
    final_report();
  end
endmodule

bind shutter_override_positioner shutter_monitor MON (.i_core_clk, .i_rst, .i_addr, .i_rd,
  .o_rdata, .i_bus_power, .o_nv_force_active, .o_nv_force_down, .o_drive, .o_supply_on,
  .o_fb_pulse, .o_fb_down);
